// file: dv/host_model.sv
// Host controller model that frames conversions on the serial link.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import adc_wake_pkg::*;
(
  // Clock
  input wire logic clock,
  // Serial link
  output logic cs_n,
  output logic sck,
  input wire logic sdo_out,
  input wire logic sdo_oe_n
);
  logic last_bit = 1'b0;
  logic sdo_wire;

  // A released data line shows the inverse of its last driven value.
  assign sdo_wire = sdo_oe_n ? ~last_bit : sdo_out;

  always @(posedge clock)
  begin
    if (!sdo_oe_n)
      last_bit <= sdo_out;
  end

  initial
  begin
    cs_n = CS_IDLE;
    sck = SCK_IDLE;
  end

  // One frame with a given count of falling edges; the clock stands still outside it.
  task automatic run_frame(input int falls, output logic [15:0] word);
    word = 16'h0000;
    cs_n = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = 0; i < falls; i++)
    begin
      sck = 1'b1;
      repeat (4) @(negedge clock);
      word = {word[14:0], sdo_wire};
      sck = 1'b0;
      repeat (4) @(negedge clock);
    end
    cs_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the sleep, wake-up and output coding block.
`timescale 1ns/1ps
`default_nettype none
module tb
  import adc_wake_pkg::*;
;
  logic clock;
  logic rst_n;
  logic cs_n;
  logic sck;
  logic sdo_out;
  logic sdo_oe_n;
  logic signed [17:0] level;
  logic hold_mode;
  logic bias_on;
  logic ready;
  logic [15:0] word;
  int num_errors = 0;
  int comparisons = 0;

  adc_sleep_wake #(.IN_W(18), .FRAC(4)) adc_sleep_wake_inst (
    .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .level(level),
    .hold_mode(hold_mode), .bias_on(bias_on), .ready(ready)
  );

  host_model host_model_inst (
    .clock(clock), .cs_n(cs_n), .sck(sck), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [CODE_BITS-1:0] expect_code(input int lv);
    int steps;
    steps = (lv + 8) / 16;
    if (lv < 0)
      steps = 0;
    if (steps > 4095)
      steps = 4095;
    return steps[CODE_BITS-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check("bias_on", 16'(bias_on), 16'h0000);
    check("ready", 16'(ready), 16'h0000);
    check("hold_mode", 16'(hold_mode), 16'h0001);
    check("sdo_oe_n", 16'(sdo_oe_n), 16'h0001);
    $display("test reset done");
  endtask

  task automatic test_wake(input int falls);
    fork
      host_model_inst.run_frame(falls, word);
      begin
        repeat (6) @(negedge clock);
        check("bias_on waking", 16'(bias_on), 16'h0001);
        check("hold before first fall", 16'(hold_mode), 16'h0001);
        repeat (8) @(negedge clock);
        check("hold after first fall", 16'(hold_mode), 16'h0000);
        check("ready early", 16'(ready), 16'h0000);
      end
    join
    // The dummy word is discarded.
    check("ready after wake", 16'(ready), (falls == 16) ? 16'h0001 : 16'h0000);
    check("bias after wake", 16'(bias_on), (falls == 16) ? 16'h0001 : 16'h0000);
    $display("test wake %0d done", falls);
  endtask

  task automatic test_codes();
    int levels[12] = '{-100000, -16, 0, 7, 8, 87, 88, 65511, 65512, 65535, 65536, 100000};
    foreach (levels[i])
    begin
      level = levels[i][17:0];
      repeat (4) @(negedge clock);
      fork
        host_model_inst.run_frame(16, word);
        begin
          repeat (6) @(negedge clock);
          check("hold at frame start", 16'(hold_mode), 16'h0001);
        end
      join
      check("frame word", word, {2'b00, expect_code(levels[i]), 2'b00});
      check("hold after frame", 16'(hold_mode), 16'h0000);
      check("sdo_oe_n after frame", 16'(sdo_oe_n), 16'h0001);
      check("ready in stream", 16'(ready), 16'h0001);
    end
    $display("test codes done");
  endtask

  task automatic test_cut_frames();
    int cuts[5] = '{2, 9, 10, 15, 1};
    logic stays;
    foreach (cuts[i])
    begin
      stays = (cuts[i] >= 10) || (cuts[i] < 2);
      host_model_inst.run_frame(cuts[i], word);
      check("bias after cut", 16'(bias_on), 16'(stays));
      check("ready after cut", 16'(ready), 16'(stays));
      check("hold after cut", 16'(hold_mode), 16'(!stays));
      check("sdo_oe_n after cut", 16'(sdo_oe_n), 16'h0001);
      if (!stays)
        test_wake(16);
    end
    $display("test cut frames done");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    repeat (50000) @(posedge clock);
    num_errors++;
    $display("BAD run time expected end seen limit");
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    level = 18'h00000;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    test_reset();
    test_wake(15);
    test_wake(16);
    test_codes();
    test_cut_frames();
    // A reset in mid-run must drop an awake device back to sleep.
    rst_n = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    test_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: rtl/adc_code_former.sv
// Turns a fine-grained input level into the clamped straight-binary result code.
`timescale 1ns/1ps
`default_nettype none
module adc_code_former
  import adc_wake_pkg::*;
#(
  parameter int IN_W = 18,
  parameter int FRAC = 4
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Level in fractions of one code step, full scale is 4096 steps
  input wire logic signed [IN_W-1:0] level,
  // Result code
  output logic [CODE_BITS-1:0] code
);

  // Refuse widths that cannot reach both saturation ends of the code range.
  if (FRAC < 1 || IN_W < CODE_BITS + FRAC + 2)
  begin
    $error("adc_code_former: input too narrow for the code range");
  end

  logic signed [IN_W:0] rounded;
  logic signed [IN_W:0] steps;
  logic [CODE_BITS-1:0] next_code;

  // ----------------------------------------------------------------
  // Rounding and clamping
  // ----------------------------------------------------------------
  always_comb
  begin
    // Adding half a step puts each boundary midway between integer steps.
    rounded = (IN_W+1)'(level) + (IN_W+1)'(1 << (FRAC - 1));
    steps = rounded >>> FRAC;
    if (steps < 0)
      next_code = CODE_MIN;
    else if (steps > $signed((IN_W+1)'(CODE_MAX)))
      next_code = CODE_MAX;
    else
      next_code = steps[CODE_BITS-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      code <= CODE_MIN;
    else
      code <= next_code;
  end

  below_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    level < 0 |=> code == CODE_MIN)
    else $error("Negative input did not give all zeros.");

  above_full_a: assert property (@(posedge clock) disable iff (!rst_n)
    level >= (IN_W)'((1 << CODE_BITS) << FRAC) |=> code == CODE_MAX)
    else $error("Input above full scale did not give all ones.");

  first_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    level == (IN_W)'(1 << (FRAC - 1)) |=> code == 12'h001)
    else $error("Half a step did not give the first code.");

endmodule
`default_nettype wire

// file: rtl/adc_sleep_wake.sv
// Serial sampling converter: sleep, wake-up, frame output and sample/hold control.
`timescale 1ns/1ps
`default_nettype none
module adc_sleep_wake
  import adc_wake_pkg::*;
#(
  parameter int IN_W = 18,
  parameter int FRAC = 4
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial link pins from the host
  input wire logic cs_n,
  input wire logic sck,
  // Serial data pin, driven while sdo_oe_n is low
  output logic sdo_out,
  output logic sdo_oe_n,
  // Analog front end
  input wire logic signed [IN_W-1:0] level,
  output logic hold_mode,
  // Power state
  output logic bias_on,
  output logic ready
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic cs_meta;
  logic cs_sync;
  logic cs_last;
  logic sck_meta;
  logic sck_sync;
  logic sck_last;
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cs_meta <= CS_IDLE;
      cs_sync <= CS_IDLE;
      cs_last <= CS_IDLE;
      sck_meta <= SCK_IDLE;
      sck_sync <= SCK_IDLE;
      sck_last <= SCK_IDLE;
    end
    else
    begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_last <= cs_sync;
      sck_meta <= sck;
      sck_sync <= sck_meta;
      sck_last <= sck_sync;
    end
  end

  assign cs_fall = cs_last & ~cs_sync;
  assign cs_rise = ~cs_last & cs_sync;
  assign sck_fall = sck_last & ~sck_sync;

  // ----------------------------------------------------------------
  // Result code
  // ----------------------------------------------------------------
  logic [CODE_BITS-1:0] code;

  adc_code_former #(
    .IN_W(IN_W),
    .FRAC(FRAC)
  ) former (
    .clock(clock),
    .rst_n(rst_n),
    .level(level),
    .code(code)
  );

  // ----------------------------------------------------------------
  // Power mode and frame sequencing
  // ----------------------------------------------------------------
  power_mode_t mode;
  power_mode_t next_mode;
  logic framing;
  logic next_framing;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [FRAME_BITS-1:0] shift;
  logic [FRAME_BITS-1:0] next_shift;
  logic next_hold_mode;
  logic next_sdo_oe_n;

  always_comb
  begin
    next_mode = mode;
    next_framing = framing;
    next_count = count;
    next_shift = shift;
    next_hold_mode = hold_mode;
    next_sdo_oe_n = sdo_oe_n;
    if (cs_fall)
    begin
      // The first leading zero appears as soon as the frame opens.
      next_framing = 1'b1;
      next_count = '0;
      next_shift = {{LEAD_ZEROS{1'b0}}, code, {TRAIL_ZEROS{1'b0}}};
      next_hold_mode = 1'b1;
      next_sdo_oe_n = 1'b0;
      if (mode == mode_sleep)
        next_mode = mode_waking;
    end
    else if (framing && cs_rise)
    begin
      next_framing = 1'b0;
      next_sdo_oe_n = 1'b1;
      unique case (mode)
        mode_waking:
        begin
          // An aborted wake-up frame leaves the device asleep.
          next_mode = mode_sleep;
          next_hold_mode = 1'b1;
        end
        mode_awake:
        begin
          if (count >= FALL_SLEEP_FIRST && count < FALL_SLEEP_LAST)
          begin
            next_mode = mode_sleep;
            next_hold_mode = 1'b1;
          end
          else
            next_hold_mode = 1'b0;
        end
        mode_sleep:
          next_hold_mode = 1'b1;
      endcase
    end
    else if (framing && sck_fall)
    begin
      next_count = count + 5'h01;
      next_shift = {shift[FRAME_BITS-2:0], 1'b0};
      if (mode == mode_waking && next_count == FALL_WAKE_SAMPLE)
        next_hold_mode = 1'b0;
      if (mode == mode_awake && next_count == FALL_CONV_DONE)
        next_hold_mode = 1'b0;
      if (next_count == FALL_FRAME_END)
      begin
        next_framing = 1'b0;
        next_sdo_oe_n = 1'b1;
        if (mode == mode_waking)
          next_mode = mode_awake;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mode <= mode_sleep;
      framing <= 1'b0;
      count <= '0;
      shift <= '0;
      hold_mode <= 1'b1;
      sdo_oe_n <= 1'b1;
    end
    else
    begin
      mode <= next_mode;
      framing <= next_framing;
      count <= next_count;
      shift <= next_shift;
      hold_mode <= next_hold_mode;
      sdo_oe_n <= next_sdo_oe_n;
    end
  end

  assign sdo_out = shift[FRAME_BITS-1];
  assign bias_on = (mode != mode_sleep);
  assign ready = (mode == mode_awake);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int wake_cnt;

  always_ff @(posedge clock)
  begin
    if (!rst_n || cs_fall)
      wake_cnt <= 0;
    else if (mode == mode_waking)
      wake_cnt <= wake_cnt + 1;
  end

  sleep_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    mode == mode_sleep |-> hold_mode)
    else $error("Sample-and-hold tracks while asleep.");

  wake_sample_a: assert property (@(posedge clock) disable iff (!rst_n)
    framing && sck_fall && mode == mode_waking && count == 5'h00 && !cs_fall
      |=> !hold_mode && !ready)
    else $error("First falling edge of wake-up did not return to sample.");

  wake_done_a: assert property (@(posedge clock) disable iff (!rst_n)
    framing && sck_fall && mode == mode_waking && count == 5'h0F && !cs_fall
      |=> ready && sdo_oe_n)
    else $error("Device not ready after the 16th falling edge.");

  wake_time_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(ready) |-> wake_cnt >= WAKE_MIN_CYC)
    else $error("Wake-up finished sooner than one frame.");

  cs_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    cs_fall |=> hold_mode && !sdo_oe_n && framing && count == 5'h00)
    else $error("Chip select fall did not open a frame in hold.");

  lead_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    framing && count < 5'h02 |-> !sdo_out)
    else $error("Leading zero missing.");

  data_float_a: assert property (@(posedge clock) disable iff (!rst_n)
    !framing |-> sdo_oe_n)
    else $error("Data driven outside a frame.");

  sleep_entry_a: assert property (@(posedge clock) disable iff (!rst_n)
    framing && cs_rise && !cs_fall && ready && count >= 5'h02 && count < 5'h0A
      |=> !bias_on ##1 hold_mode)
    else $error("Early chip select rise did not enter sleep.");

  keep_awake_a: assert property (@(posedge clock) disable iff (!rst_n)
    framing && cs_rise && !cs_fall && ready && count >= 5'h0A |=> ready && !hold_mode)
    else $error("Late chip select rise lost power.");

  conv_done_a: assert property (@(posedge clock) disable iff (!rst_n)
    framing && sck_fall && ready && count == 5'h0D && !cs_fall |=> !hold_mode)
    else $error("Sample not resumed at the 14th falling edge.");

endmodule
`default_nettype wire

// file: rtl/adc_wake_pkg.sv
// Shared constants for the converter wake-up, framing and output coding logic.
package adc_wake_pkg;

  // ----------------------------------------------------------------
  // Code and frame layout
  // ----------------------------------------------------------------
  localparam int CODE_BITS = 12;
  localparam int FRAME_BITS = 16;
  localparam int LEAD_ZEROS = 2;
  localparam int TRAIL_ZEROS = 2;
  localparam int COUNT_W = 5;
  localparam logic [CODE_BITS-1:0] CODE_MIN = 12'h000;
  localparam logic [CODE_BITS-1:0] CODE_MAX = 12'hFFF;

  // ----------------------------------------------------------------
  // Falling-edge positions inside a frame
  // ----------------------------------------------------------------
  localparam logic [COUNT_W-1:0] FALL_WAKE_SAMPLE = 5'h01;
  localparam logic [COUNT_W-1:0] FALL_SLEEP_FIRST = 5'h02;
  localparam logic [COUNT_W-1:0] FALL_SLEEP_LAST = 5'h0A;
  localparam logic [COUNT_W-1:0] FALL_CONV_DONE = 5'h0E;
  localparam logic [COUNT_W-1:0] FALL_FRAME_END = 5'h10;

  // ----------------------------------------------------------------
  // Wake-up timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 250;
  localparam int WAKE_FAST_NS = 333;
  localparam int SCK_FAST_MHZ = 48;
  localparam int WAKE_SLOW_NS = 1000;
  localparam int SCK_SLOW_MHZ = 16;
  localparam int WAKE_MIN_CYC = WAKE_FAST_NS * CLOCK_MHZ / 1000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CS_IDLE = 1'b1;
  localparam logic SCK_IDLE = 1'b0;

  typedef enum logic [1:0] {mode_sleep, mode_waking, mode_awake} power_mode_t;

endpackage
